// ---- rtl/dawc_top.v ----
// What this block does
// - inhibit bit freezes the bus address
// - address bit zero always zero, even
// - low stage carry all ones, borrow zeros
// - reverse code on go sets count down
// - address plus extension onto selected port
// - read selector gives address or word count
// - hidden drive word counter stops run
// - counters load negative length, count up
// - counters load on full word write only
// - drive clock only without overflow or error
// - counters step on trailing strobe edge, drive counter on drive clock rise
// - counter carry sets matching overflow flag
// - word counters have no clear input
// - selector never drives two sources
// - port A init gives drive link init
// - go command pulses go clear
// - clear bit gives program clear pulse
// - port B init clears, posts data late
// - clear or go clears flags and done
// - done after overflow and last request
// - error gives done, ready waits segment end
// - last word flag suppresses late, prefetch
// - interrupt sequence only when enabled
// - count down flag picks address direction
// - extension bits writable only when ready
`timescale 1ns/1ns
`include "dawc_consts.vh"
module dawc_top (
    // clock and reset
    input wire mclk,
    input wire reset_n,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg pready,
    output reg [31:0] prdata,
    output reg pslverr,
    // pins from the drive link and both host ports
    input wire drive_clk,
    input wire transfer_error,
    input wire end_of_segment,
    input wire port_a_init,
    input wire port_a_power_low,
    input wire port_b_init,
    input wire port_b_power_low,
    // strobes from the local transfer logic
    input wire address_out_strobe,
    input wire host_word_increment,
    input wire data_req,
    input wire npr_active,
    input wire late_condition,
    input wire interrupt_request,
    // address drive for the two host ports
    output reg [17:0] port_a_addr,
    output reg port_a_addr_oe,
    output reg [17:0] port_b_addr,
    output reg port_b_addr_oe,
    // control outputs
    output reg go_clear_pulse,
    output reg program_clear_pulse,
    output reg port_b_clear,
    output reg drive_link_init,
    output reg drive_word_clk,
    output reg drive_run,
    output reg prefetch_enable,
    output reg interrupt_start
);

    // two-flop synchronisers for every asynchronous pin
    wire [6:0] pin_raw;
    wire [6:0] pin_s;
    reg [6:0] sync1_q;
    reg [6:0] sync2_q;
    assign pin_raw = {port_b_power_low, port_b_init, port_a_power_low, port_a_init,
                      end_of_segment, transfer_error, drive_clk};
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi = gi + 1) begin : g_sync
            always @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= pin_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate
    assign pin_s = sync2_q;
    wire dclk_s = pin_s[0];
    wire tre_s = pin_s[1];
    wire eos_s = pin_s[2];
    wire init_a = pin_s[3] | pin_s[4];
    wire init_b = pin_s[5] | pin_s[6];

    // edge history for strobes; a trailing edge is the end of the active level
    reg dclk_q, aos_q, hwi_q, dreq_q, eos_q, init_a_q, init_b_q;
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dclk_q <= 1'b0;
            aos_q <= 1'b0;
            hwi_q <= 1'b0;
            dreq_q <= 1'b0;
            eos_q <= 1'b0;
            init_a_q <= 1'b0;
            init_b_q <= 1'b0;
        end else begin
            dclk_q <= dclk_s;
            aos_q <= address_out_strobe;
            hwi_q <= host_word_increment;
            dreq_q <= data_req;
            eos_q <= eos_s;
            init_a_q <= init_a;
            init_b_q <= init_b;
        end
    end
    wire dclk_edge = dclk_s & ~dclk_q;
    wire aos_end = aos_q & ~address_out_strobe;
    wire hwi_end = hwi_q & ~host_word_increment;
    wire dreq_end = dreq_q & ~data_req;
    wire eos_rise = eos_s & ~eos_q;

    // apb decode; the register write lands at the edge that sees pready
    wire acc = psel & penable;
    wire wr_en = acc & pwrite & pready;
    wire hit_cs1 = (paddr == `DAWC_OFF_CS1);
    wire hit_wc = (paddr == `DAWC_OFF_WC);
    wire hit_ba = (paddr == `DAWC_OFF_BA);
    wire hit_cs2 = (paddr == `DAWC_OFF_CS2);
    wire hit_st = (paddr == `DAWC_OFF_STAT);
    wire mapped = hit_cs1 | hit_wc | hit_ba | hit_cs2 | hit_st;
    wire full_word = pstrb[0] & pstrb[1];

    // control state
    reg [15:0] cs1_q;
    reg cs2_bai_q;
    reg [15:0] ba_q;
    reg [15:0] hwc_q;
    reg [15:0] dwc_q;
    reg cdown_q, hovf_q, dovf_q, done_q, ready_q, busy_q, last_word_flag_q, dlt_q;

    // command decode: go with a data transfer code
    wire go_wr = wr_en & hit_cs1 & pstrb[0] & pwdata[`DAWC_CS1_GO] & pwdata[`DAWC_CS1_XFER];
    wire pg_wr = wr_en & hit_cs2 & pstrb[0] & pwdata[`DAWC_CS2_CLR];
    // port A init clears the controller like a program clear
    wire ctl_clear = pg_wr | init_a;
    wire clr_or_go = ctl_clear | go_wr;

    // clear pulses and the link init level, registered so they leave straight from flops
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            go_clear_pulse <= 1'b0;
            program_clear_pulse <= 1'b0;
            port_b_clear <= 1'b0;
            drive_link_init <= 1'b0;
        end else begin
            go_clear_pulse <= go_wr;
            program_clear_pulse <= pg_wr | (init_a & ~init_a_q);
            port_b_clear <= init_b & ~init_b_q;
            drive_link_init <= init_a;
        end
    end

    // control_status_one and control_status_two
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cs1_q <= `DAWC_RST_16;
            cs2_bai_q <= 1'b0;
            cdown_q <= 1'b0;
        end else if (ctl_clear) begin
            cs1_q <= `DAWC_RST_16;
            cs2_bai_q <= 1'b0;
            cdown_q <= 1'b0;
        end else begin
            if (wr_en & hit_cs1 & pstrb[0])
                cs1_q[7:1] <= pwdata[7:1];
            // extension bits only change in the ready state, so commands
            // passed on to other drives cannot move them
            if (wr_en & hit_cs1 & pstrb[1] & ready_q) begin
                cs1_q[`DAWC_CS1_EXT_HI:`DAWC_CS1_EXT_LO] <= pwdata[9:8];
                cs1_q[`DAWC_CS1_PSEL] <= pwdata[`DAWC_CS1_PSEL];
            end
            if (wr_en & hit_cs2 & pstrb[1])
                cs2_bai_q <= pwdata[`DAWC_CS2_BAI];
            if (go_wr)
                cdown_q <= pwdata[`DAWC_CS1_REV_LO] & pwdata[`DAWC_CS1_REV_HI];
        end
    end

    // bus address counter: bit 0 is not stored, so the address is always even
    // low stage holds bits 3:1, its carry and borrow are decoded by hand
    wire [2:0] ba_low = ba_q[3:1];
    wire low_carry = &ba_low;
    wire low_borrow = ~|ba_low;
    wire ba_step = aos_end & ~cs2_bai_q;
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ba_q <= `DAWC_RST_16;
        end else if (ctl_clear) begin
            ba_q <= `DAWC_RST_16;
        end else if (wr_en & hit_ba) begin
            if (pstrb[0])
                ba_q[7:1] <= pwdata[7:1];
            if (pstrb[1])
                ba_q[15:8] <= pwdata[15:8];
        end else if (ba_step) begin
            if (cdown_q) begin
                ba_q[3:1] <= ba_low - 3'h1;
                if (low_borrow)
                    ba_q[15:4] <= ba_q[15:4] - 12'h001;
            end else begin
                ba_q[3:1] <= ba_low + 3'h1;
                if (low_carry)
                    ba_q[15:4] <= ba_q[15:4] + 12'h001;
            end
        end
    end

    // word counters: no clear, software reloads them before each transfer
    wire wc_load = wr_en & hit_wc & full_word;
    wire dclk_issue = dclk_edge & ~dovf_q & ~tre_s;
    wire hwc_carry = hwi_end & (&hwc_q);
    wire dwc_carry = dclk_issue & (&dwc_q);
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            hwc_q <= `DAWC_RST_16;
            dwc_q <= `DAWC_RST_16;
        end else if (wc_load) begin
            hwc_q <= pwdata[15:0];
            dwc_q <= pwdata[15:0];
        end else begin
            if (hwi_end)
                hwc_q <= hwc_q + 16'h0001;
            if (dclk_issue)
                dwc_q <= dwc_q + 16'h0001;
        end
    end

    // overflow, done, ready, busy; for overflow and done a set in the same cycle as a clear wins, for busy the clear wins
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            hovf_q <= 1'b0;
            dovf_q <= 1'b0;
            done_q <= 1'b0;
            ready_q <= 1'b1;
            busy_q <= 1'b0;
        end else begin
            if (hwc_carry)
                hovf_q <= 1'b1;
            else if (clr_or_go)
                hovf_q <= 1'b0;
            if (dwc_carry)
                dovf_q <= 1'b1;
            else if (clr_or_go)
                dovf_q <= 1'b0;
            if (dreq_end & (hovf_q | tre_s))
                done_q <= 1'b1;
            else if (clr_or_go)
                done_q <= 1'b0;
            if (ctl_clear)
                ready_q <= 1'b1;
            else if (go_wr)
                ready_q <= 1'b0;
            else if (dreq_end & hovf_q & ~tre_s)
                ready_q <= 1'b1;
            else if (eos_rise & tre_s)
                ready_q <= 1'b1;
            if (ctl_clear | (dreq_end & hovf_q) | eos_rise)
                busy_q <= 1'b0;
            else if (go_wr)
                busy_q <= 1'b1;
        end
    end

    // last word flag is taken at the drive clock edge from the drive carry
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            last_word_flag_q <= 1'b0;
            dlt_q <= 1'b0;
        end else begin
            if (dclk_edge)
                last_word_flag_q <= dovf_q | dwc_carry;
            else if (clr_or_go)
                last_word_flag_q <= 1'b0;
            // port B clear flags data late on a running port B transfer
            if ((init_b & ~init_b_q & busy_q & cs1_q[`DAWC_CS1_PSEL]) | (late_condition & busy_q & ~last_word_flag_q))
                dlt_q <= 1'b1;
            else if (clr_or_go)
                dlt_q <= 1'b0;
        end
    end

    // link-side and interrupt outputs
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            drive_word_clk <= 1'b0;
            drive_run <= 1'b0;
            prefetch_enable <= 1'b0;
            interrupt_start <= 1'b0;
        end else begin
            drive_word_clk <= dclk_issue;
            drive_run <= busy_q & ~dovf_q & ~dwc_carry;
            // the carry cycle itself already counts as the last word
            prefetch_enable <= busy_q & ~last_word_flag_q & ~dovf_q & ~dwc_carry;
            interrupt_start <= interrupt_request & cs1_q[`DAWC_CS1_IE];
        end
    end

    // npr address onto whichever host port is selected; never both at once
    wire [17:0] npr_addr = {cs1_q[`DAWC_CS1_EXT_HI], cs1_q[`DAWC_CS1_EXT_LO], ba_q[15:1], 1'b0};
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            port_a_addr <= 18'h00000;
            port_a_addr_oe <= 1'b0;
            port_b_addr <= 18'h00000;
            port_b_addr_oe <= 1'b0;
        end else begin
            port_a_addr <= npr_addr;
            port_b_addr <= npr_addr;
            port_a_addr_oe <= npr_active & ~cs1_q[`DAWC_CS1_PSEL];
            port_b_addr_oe <= npr_active & cs1_q[`DAWC_CS1_PSEL];
        end
    end

    // read selector: one-hot source choice, idle value zero; the drive
    // counter has no read path on purpose
    reg [15:0] internal_read_bus;
    always @* begin
        internal_read_bus = 16'h0000;
        if (hit_ba)
            internal_read_bus = {ba_q[15:1], 1'b0};
        else if (hit_wc)
            internal_read_bus = hwc_q;
        else if (hit_cs1)
            internal_read_bus = {4'h0, busy_q, cs1_q[10:8], ready_q, cs1_q[6:1], busy_q};
        else if (hit_cs2)
            internal_read_bus = {7'h00, cs2_bai_q, 8'h00};
        else if (hit_st)
            internal_read_bus = {8'h00, busy_q, cdown_q, dlt_q, last_word_flag_q, dovf_q, hovf_q, ready_q, done_q};
    end

    // apb answer: one wait state so read data leaves from a flop
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pready <= 1'b0;
            prdata <= `DAWC_RST_32;
            pslverr <= 1'b0;
        end else if (acc & ~pready) begin
            pready <= 1'b1;
            prdata <= pwrite ? `DAWC_RST_32 : {16'h0000, internal_read_bus};
            pslverr <= ~mapped;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule // dawc_top

// ---- rtl/dawc_consts.vh ----
`ifndef DAWC_CONSTS_VH
`define DAWC_CONSTS_VH
// register byte offsets
`define DAWC_OFF_CS1 12'h000
`define DAWC_OFF_WC 12'h004
`define DAWC_OFF_BA 12'h008
`define DAWC_OFF_CS2 12'h00c
`define DAWC_OFF_STAT 12'h010
// control_status_one fields
`define DAWC_CS1_GO 0
`define DAWC_CS1_REV_LO 1
`define DAWC_CS1_REV_HI 2
`define DAWC_CS1_XFER 5
`define DAWC_CS1_IE 6
`define DAWC_CS1_EXT_LO 8
`define DAWC_CS1_EXT_HI 9
`define DAWC_CS1_PSEL 10
// control_status_two fields
`define DAWC_CS2_CLR 5
`define DAWC_CS2_BAI 8
// status register fields
`define DAWC_ST_DONE 0
`define DAWC_ST_READY 1
`define DAWC_ST_HOVF 2
`define DAWC_ST_DOVF 3
`define DAWC_ST_LAST_WORD_FLAG 4
`define DAWC_ST_DLT 5
`define DAWC_ST_CDOWN 6
`define DAWC_ST_BUSY 7
// reset values
`define DAWC_RST_16 16'h0000
`define DAWC_RST_32 32'h00000000
`endif

// ---- test/dawc_chk.sv ----
`timescale 1ns/1ns
module dawc_chk (
    // clock and reset
    input wire mclk,
    input wire reset_n,
    // apb slave side
    input wire psel,
    input wire penable,
    input wire pready,
    input wire [31:0] prdata,
    input wire pslverr,
    // host address drive
    input wire npr_active,
    input wire [17:0] port_a_addr,
    input wire port_a_addr_oe,
    input wire port_b_addr_oe,
    // control pins
    input wire interrupt_request,
    input wire interrupt_start,
    input wire go_clear_pulse,
    input wire prefetch_enable,
    input wire drive_run,
    input wire port_a_init,
    input wire drive_link_init
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // address and port selection, seen only at the pins
    addr_even_a: assert property (port_a_addr[0] == 1'b0) else $error("odd host address");
    port_excl_a: assert property (!(port_a_addr_oe && port_b_addr_oe)) else $error("both ports driven");
    port_drive_a: assert property ((port_a_addr_oe | port_b_addr_oe) == $past(npr_active))
        else $error("address drive not tied to npr");
    // one wait state, then a single answer cycle
    apb_answer_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb answer timing wrong");
    err_read_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("refused access leaks");
    irq_gate_a: assert property (interrupt_start |-> $past(interrupt_request)) else $error("interrupt without request");
    go_pulse_a: assert property ($rose(go_clear_pulse) |=> !go_clear_pulse) else $error("go clear too long");
    prefetch_run_a: assert property (prefetch_enable |-> drive_run) else $error("prefetch while stopped");
    // the pin passes two sync stages before the link init shows
    link_init_a: assert property ($rose(port_a_init) |-> ##[2:4] drive_link_init)
        else $error("link init missing");

    cover property (go_clear_pulse);
    cover property (interrupt_start);
    cover property (pslverr);
endmodule // dawc_chk

// ---- test/dawc_host_model.sv ----
`timescale 1ns/1ns
module dawc_host_model (
    // clock
    input wire mclk,
    // control from the bench
    input wire start,
    input wire [3:0] words,
    input wire slow,
    // per-word strobes
    output reg data_req,
    output reg address_out_strobe,
    output reg host_word_increment,
    output reg drive_clk,
    output reg idle
);
    // one word: address strobe, memory word, drive word; slow stretches the request
    initial begin
        {data_req, address_out_strobe, host_word_increment, drive_clk} = 4'h0;
        idle = 1'b1;
        forever begin
            @(posedge mclk);
            if (start) begin
                idle <= 1'b0;
                repeat (words) begin
                    data_req <= 1'b1;
                    repeat (slow ? 5 : 1) @(posedge mclk);
                    address_out_strobe <= 1'b1;
                    @(posedge mclk);
                    address_out_strobe <= 1'b0;
                    host_word_increment <= 1'b1;
                    @(posedge mclk);
                    host_word_increment <= 1'b0;
                    drive_clk <= 1'b1;
                    // held three cycles so the two-stage sync catches it
                    repeat (3) @(posedge mclk);
                    drive_clk <= 1'b0;
                    data_req <= 1'b0;
                    repeat (3) @(posedge mclk);
                end
                idle <= 1'b1;
            end
        end
    end
endmodule // dawc_host_model

// ---- test/dawc_top_test.sv ----
`timescale 1ns/1ns
`include "dawc_consts.vh"
module dawc_top_test;
    localparam [32:0] M16 = 33'h1_0000_ffff;
    reg mclk = 1'b0;
    reg reset_n = 1'b0;
    reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, start = 1'b0, slow = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0, seed = 32'h79410a66;
    reg [3:0] pstrb = 4'h0, words = 4'h0;
    reg transfer_error = 1'b0, end_of_segment = 1'b0, port_a_init = 1'b0, port_b_init = 1'b0;
    reg npr_active = 1'b0, interrupt_request = 1'b0, late_condition = 1'b0;
    wire pready, pslverr, port_a_addr_oe, port_b_addr_oe, go_clear_pulse, program_clear_pulse, port_b_clear;
    wire drive_link_init, drive_word_clk, drive_run, prefetch_enable, interrupt_start;
    wire data_req, address_out_strobe, host_word_increment, drive_clk, idle;
    wire [31:0] prdata;
    wire [17:0] port_a_addr, port_b_addr;
    reg [15:0] ba;
    reg [65:0] q[$];
    reg [65:0] qe;
    integer failures = 0, comparisons = 0, cyc = 0, ints = 0, pbc = 0, dwn = 0;

    always #2 mclk = ~mclk;

    dawc_top u_dut (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .drive_clk(drive_clk), .transfer_error(transfer_error), .end_of_segment(end_of_segment),
        .port_a_init(port_a_init), .port_a_power_low(1'b0), .port_b_init(port_b_init), .port_b_power_low(1'b0),
        .address_out_strobe(address_out_strobe), .host_word_increment(host_word_increment), .data_req(data_req),
        .npr_active(npr_active), .late_condition(late_condition), .interrupt_request(interrupt_request),
        .port_a_addr(port_a_addr), .port_a_addr_oe(port_a_addr_oe), .port_b_addr(port_b_addr),
        .port_b_addr_oe(port_b_addr_oe), .go_clear_pulse(go_clear_pulse), .program_clear_pulse(program_clear_pulse),
        .port_b_clear(port_b_clear), .drive_link_init(drive_link_init), .drive_word_clk(drive_word_clk),
        .drive_run(drive_run), .prefetch_enable(prefetch_enable), .interrupt_start(interrupt_start));

    dawc_host_model u_host (.mclk(mclk), .start(start), .words(words), .slow(slow), .data_req(data_req),
        .address_out_strobe(address_out_strobe), .host_word_increment(host_word_increment),
        .drive_clk(drive_clk), .idle(idle));

    function [15:0] rnd;
        begin
            seed = seed ^ (seed << 13);
            seed = seed ^ (seed >> 17);
            seed = seed ^ (seed << 5);
            rnd = seed[15:0];
        end
    endfunction

    task check(input string nm, input [32:0] seen, input [32:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("[ERR] %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask

    task final_report;
        begin
            $display("comparisons %0d failures %0d", comparisons, failures);
            if (failures == 0 && comparisons > 0) begin
                $display("DONE - PASS");
            end else begin
                $display("DONE - FAIL");
            end
            $finish;
        end
    endtask

    // request held until pready is sampled high, then an idle cycle
    task apb(input w, input [11:0] a, input [31:0] d, input [3:0] s);
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            pstrb <= s;
            @(posedge mclk);
            penable <= 1'b1;
            do @(posedge mclk); while (pready !== 1'b1);
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge mclk);
        end
    endtask

    task wr(input [11:0] a, input [31:0] d, input [3:0] s);
        apb(1'b1, a, d, s);
    endtask

    // the expectation is queued before the access starts
    task rd(input [11:0] a, input [32:0] m, input [32:0] e);
        begin
            q.push_back({m, e});
            apb(1'b0, a, 32'h0, 4'h0);
        end
    endtask

    task xfer(input [3:0] n);
        begin
            words <= n;
            start <= 1'b1;
            @(posedge mclk);
            start <= 1'b0;
            do @(posedge mclk); while (idle !== 1'b1);
            repeat (4) @(posedge mclk);
        end
    endtask

    // read answers are matched against the oldest note
    always @(posedge mclk) begin
        if (psel && penable && !pwrite && pready === 1'b1 && q.size() > 0) begin
            qe = q.pop_front();
            check($sformatf("read %h", paddr), {pslverr, prdata} & qe[65:33], qe[32:0]);
        end
        if (interrupt_start === 1'b1) ints = ints + 1;
        if (port_b_clear === 1'b1) pbc = pbc + 1;
        if (drive_word_clk === 1'b1) dwn = dwn + 1;
        cyc = cyc + 1;
        if (cyc == 5000) begin
            failures = failures + 1;
            final_report;
        end
    end

    initial begin
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(`DAWC_OFF_STAT, M16, 33'h2);
        rd(12'h014, 33'h1_ffff_ffff, 33'h1_0000_0000);
        ba = rnd();
        ba[3:0] = 4'he;
        wr(`DAWC_OFF_BA, {16'h0, ba | 16'h1}, 4'h3);
        rd(`DAWC_OFF_BA, M16, {17'h0, ba});
        wr(`DAWC_OFF_CS1, 32'h300, 4'h2);
        wr(`DAWC_OFF_WC, 32'hfffd, 4'h1);
        rd(`DAWC_OFF_WC, M16, 33'h0);
        wr(`DAWC_OFF_WC, 32'hfffd, 4'h3);
        rd(`DAWC_OFF_WC, M16, 33'hfffd);
        npr_active <= 1'b1;
        wr(`DAWC_OFF_CS1, 32'h21, 4'h1);
        check("go_clear_pulse", {32'h0, go_clear_pulse}, 33'h1);
        rd(`DAWC_OFF_STAT, 33'h1_0000_00c2, 33'h80);
        xfer(4'h3);
        ba = ba + 16'h6;
        check("port_a_addr", {14'h0, port_a_addr_oe, port_a_addr}, {14'h0, 1'b1, 2'b11, ba});
        npr_active <= 1'b0;
        rd(`DAWC_OFF_BA, M16, {17'h0, ba});
        rd(`DAWC_OFF_STAT, 33'h1_0000_000f, 33'hf);
        check("drive_run", {32'h0, drive_run}, 33'h0);
        wr(`DAWC_OFF_CS2, 32'h20, 4'h1);
        check("program_clear_pulse", {32'h0, program_clear_pulse}, 33'h1);
        rd(`DAWC_OFF_STAT, 33'h1_0000_000d, 33'h0);
        // address held by the inhibit bit, then stepped down
        wr(`DAWC_OFF_CS1, 32'h300, 4'h2);
        wr(`DAWC_OFF_BA, 32'h10, 4'h3);
        wr(`DAWC_OFF_CS2, 32'h100, 4'h2);
        wr(`DAWC_OFF_WC, 32'hfffe, 4'h3);
        wr(`DAWC_OFF_CS1, 32'h27, 4'h1);
        rd(`DAWC_OFF_STAT, 33'h1_0000_0040, 33'h40);
        wr(`DAWC_OFF_CS1, 32'h0, 4'h2);
        rd(`DAWC_OFF_CS1, 33'h1_0000_0300, 33'h300);
        slow <= 1'b1;
        xfer(4'h2);
        rd(`DAWC_OFF_BA, M16, 33'h10);
        wr(`DAWC_OFF_CS2, 32'h0, 4'h2);
        wr(`DAWC_OFF_WC, 32'hffff, 4'h3);
        wr(`DAWC_OFF_CS1, 32'h27, 4'h1);
        xfer(4'h1);
        rd(`DAWC_OFF_BA, M16, 33'he);
        // error ends the request but ready waits for segment end
        wr(`DAWC_OFF_WC, 32'hfffc, 4'h3);
        wr(`DAWC_OFF_CS1, 32'h21, 4'h1);
        transfer_error <= 1'b1;
        late_condition <= 1'b1;
        xfer(4'h1);
        rd(`DAWC_OFF_STAT, 33'h1_0000_0023, 33'h21);
        end_of_segment <= 1'b1;
        repeat (6) @(posedge mclk);
        rd(`DAWC_OFF_STAT, 33'h1_0000_0003, 33'h3);
        transfer_error <= 1'b0;
        late_condition <= 1'b0;
        end_of_segment <= 1'b0;
        interrupt_request <= 1'b1;
        @(posedge mclk);
        interrupt_request <= 1'b0;
        wr(`DAWC_OFF_CS1, 32'h40, 4'h1);
        interrupt_request <= 1'b1;
        @(posedge mclk);
        interrupt_request <= 1'b0;
        repeat (3) @(posedge mclk);
        check("interrupt_start", ints, 33'h1);
        port_a_init <= 1'b1;
        port_b_init <= 1'b1;
        repeat (6) @(posedge mclk);
        check("drive_link_init", {32'h0, drive_link_init}, 33'h1);
        port_a_init <= 1'b0;
        port_b_init <= 1'b0;
        repeat (6) @(posedge mclk);
        check("port_b_clear", pbc, 33'h1);
        check("drive_word_clk", dwn, 33'h6);
        final_report;
    end
endmodule // dawc_top_test

bind dawc_top dawc_chk u_chk (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .npr_active(npr_active), .port_a_addr(port_a_addr),
    .port_a_addr_oe(port_a_addr_oe), .port_b_addr_oe(port_b_addr_oe), .interrupt_request(interrupt_request),
    .interrupt_start(interrupt_start), .go_clear_pulse(go_clear_pulse), .prefetch_enable(prefetch_enable),
    .drive_run(drive_run), .port_a_init(port_a_init), .drive_link_init(drive_link_init));
